/* dv/jtid_chk_props.sv */
`timescale 1ns/10ps
module jtid_chk
  import jtid_pkg::*;
(
  input wire logic        clk_sys,    // clock
  input wire logic        rst,        // sync reset
  input wire logic        glob_rst_n, // global reset
  input wire logic        pll_lock,   // pll lock
  input wire logic        tck,        // test clock
  input wire logic        trst_n,     // test reset
  input wire logic [31:0] sec_reg,    // security bits
  input wire logic        tdo,        // data out
  input wire logic        tdo_oe_n,   // tdo enable
  input wire logic        acc_req,    // access pulse
  input wire logic [1:0]  acc_tgt,    // access target
  input wire logic        boot_go,    // boot start
  input wire logic        boot_otp,   // boot source
  input wire logic        jtag_off    // port off
);
  // ********
  // checks
  // ********
  default clocking cb @(posedge clk_sys);
  endclocking
  sequence s_trst_held;
    !trst_n [*5];
  endsequence
  sequence s_glob_held;
    !glob_rst_n [*3];
  endsequence
  property p_rst_quiet;
    rst |=> tdo_oe_n && !tdo && !boot_go && !acc_req && !jtag_off;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("output active after reset");
  property p_glob_quiet;
    disable iff (rst) s_glob_held |-> tdo_oe_n && !boot_go && !acc_req;
  endproperty
  a_glob_quiet: assert property (p_glob_quiet)
    else $error("global reset did not hold outputs");
  // allows for the two sync flops plus the registered tdo and enable outputs
  property p_trst_hold;
    disable iff (rst) s_trst_held |-> tdo_oe_n && !tdo;
  endproperty
  a_trst_hold: assert property (p_trst_hold)
    else $error("test reset did not hold the taps");
  property p_off_hold;
    disable iff (rst) jtag_off [*3] |-> tdo_oe_n && !acc_req;
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("disabled port still active");
  property p_off_copy;
    disable iff (rst) $rose(jtag_off) |-> $past(sec_reg[SEC_JTAG_OFF]);
  endproperty
  a_off_copy: assert property (p_off_copy)
    else $error("port off without security bit");
  property p_boot_lock;
    disable iff (rst)
      $rose(boot_go) |-> $past(pll_lock, 2) && $past(pll_lock, 3);
  endproperty
  a_boot_lock: assert property (p_boot_lock)
    else $error("boot started without lock");
  property p_boot_src;
    disable iff (rst)
      $rose(boot_go) |-> boot_otp == $past(sec_reg[SEC_BOOT_OTP]);
  endproperty
  a_boot_src: assert property (p_boot_src)
    else $error("boot source wrong");
  property p_req_pulse;
    disable iff (rst) acc_req |=> !acc_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("access request longer than one cycle");
  property p_otp_block;
    disable iff (rst)
      acc_req && acc_tgt == TGT_OTP |-> !$past(sec_reg[SEC_OTP_OFF]);
  endproperty
  a_otp_block: assert property (p_otp_block)
    else $error("fused memory reached while blocked");
  property p_tdo_fall;
    disable iff (rst)
      $changed(tdo) && !tdo_oe_n |-> !$past(tck, 2) && !$past(tck, 3);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("tdo moved off the falling half");
endmodule // jtid_chk

bind jtid_top jtid_chk chk_u (
  .clk_sys, .rst, .glob_rst_n, .pll_lock, .tck, .trst_n, .sec_reg,
  .tdo, .tdo_oe_n, .acc_req, .acc_tgt, .boot_go, .boot_otp, .jtag_off
);

/* dv/jtid_tester.sv */
`timescale 1ns/10ps
module jtid_tester (
  output logic     tck,    // link clock
  output logic     tms,    // mode select
  output logic     tdi,    // chain input
  output logic     trst_n, // test reset
  input wire logic tdo     // chain output
);
  // ********
  // tester
  // ********
  initial begin
    tck = 1'b0; // still between scans
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b0;
  end
  task automatic set_trst(input logic v);
    trst_n = v;
  endtask
  // tms, tdi move with tck low; tdo read just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #160;
    q = tdo;
    tck = 1'b1;
    #160;
    tck = 1'b0;
  endtask
  task automatic tlr_rti;
    logic q;
    repeat (5) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
  // idle tdi toggles so a stale level is never mistaken for data
  task automatic scan(input logic ir_path, input logic [63:0] din,
                      input int n, output logic [63:0] dout);
    logic q;
    dout = 64'h0;
    step(1'b1, ~tdi, q);
    if (ir_path) begin
      step(1'b1, ~tdi, q);
    end
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
endmodule // jtid_tester

/* dv/jtid_top_tb.sv */
`timescale 1ns/10ps
module jtid_top_tb;
  import jtid_pkg::*;
  localparam logic [31:0] IDC = {IDC_VERSION, IDC_PART, IDC_MANUF, 1'b1};
  logic                clk_sys;
  logic                rst, glob_rst_n, pll_lock;
  logic                tck, tms, tdi, trst_n, tdo, tdo_oe_n;
  logic [31:0]         sec_reg, acc_rdata, acc_wdata, req_dat;
  logic [NPIN-1:0]     pin_in, pin_out;
  logic                pin_ext, acc_req, boot_go, boot_otp, jtag_off;
  logic [1:0]          acc_tgt, req_tgt;
  logic [63:0]         got;
  int fail_count = 0, check_count = 0, cyc_cnt = 0, req_cnt = 0, oe_cnt = 0;
  jtid_top dut_u (
    .clk_sys, .rst, .glob_rst_n, .pll_lock, .tck, .tms, .tdi, .trst_n,
    .sec_reg, .pin_in, .acc_rdata, .tdo, .tdo_oe_n, .pin_out, .pin_ext,
    .acc_req, .acc_tgt, .acc_wdata, .boot_go, .boot_otp, .jtag_off
  );
  jtid_tester tst_u (.tck, .tms, .tdi, .trst_n, .tdo);
  // ********
  // harness
  // ********
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (acc_req === 1'b1) begin
      req_cnt <= req_cnt + 1;
      req_tgt <= acc_tgt;
      req_dat <= acc_wdata;
    end
    // only this process writes the count; tests take a base instead
    if (tdo_oe_n !== 1'b1) begin
      oe_cnt <= oe_cnt + 1;
    end
    if (cyc_cnt == 20000) begin
      fail_count++;
      close_out;
    end
  end
  task automatic chk(input string what, input logic [63:0] seen,
                     input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic ir(input logic [7:0] code);
    tst_u.scan(1'b1, {56'h0, code}, 8, got);
    chk("ir_capture", got, 64'h11);
  endtask
  task automatic dr(input logic [63:0] din, input int n);
    tst_u.scan(1'b0, din, n, got);
  endtask
  // ********
  // tests
  // ********
  task automatic t_boot;
    cyc(10);
    chk("boot_early", boot_go, 1'b0);
    pll_lock = 1'b1;
    cyc(6);
    chk("boot_go", boot_go, 1'b1);
    chk("boot_src", boot_otp, 1'b0);
    $display("test boot done");
  endtask
  task automatic t_ident;
    tst_u.tlr_rti;
    dr(64'h0, 64);
    chk("id_chain", got, {IDC, IDC});
    chk("id_lsb", got[0], 1'b1);
    $display("test ident done");
  endtask
  task automatic t_ucode(input logic [9:0] uid);
    sec_reg[SEC_UID_HI:SEC_UID_LO] = uid;
    ir({IR_USER, IR_USER});
    dr(64'h0, 64);
    chk("ucode", got[31:0], {uid, UC_UNUSED, UC_REVISION});
    $display("test ucode done");
  endtask
  task automatic t_pins;
    ir({IR_EXTEST, IR_EXTEST});
    dr({55'h0, 8'ha5, 1'b0}, 9);
    chk("pin_cap", got[8:1], pin_in);
    chk("pin_upd", pin_out, 8'ha5);
    chk("pin_ext", pin_ext, 1'b1);
    ir({IR_SAMPLE, IR_SAMPLE});
    dr(64'h0, 9);
    chk("sample_cap", got[8:1], pin_in);
    chk("sample_ext", pin_ext, 1'b0);
    ir({IR_BYPASS, IR_BYPASS});
    dr(64'hff, 8);
    chk("bypass", got, 64'hfc);
    $display("test pins done");
  endtask
  task automatic t_chip;
    ir({IR_CHIPACC, IR_CHIPACC});
    dr({30'h0, TGT_SWITCH, 32'h1234_5678}, 35);
    chk("acc_cap", got[31:0], acc_rdata);
    chk("acc_cnt", req_cnt, 64'h1);
    chk("acc_tgt", req_tgt, TGT_SWITCH);
    chk("acc_dat", req_dat, 32'h1234_5678);
    sec_reg[SEC_OTP_OFF] = 1'b1;
    dr({30'h0, TGT_OTP, 32'h0}, 35);
    chk("otp_cnt", req_cnt, 64'h1);
    dr(64'h0, 35);
    chk("otp_cap", got[31:0], 32'h0);
    sec_reg[SEC_OTP_OFF] = 1'b0;
    $display("test chip done");
  endtask
  task automatic t_trst;
    logic q;
    ir({IR_USER, IR_USER});
    tst_u.set_trst(1'b0);
    cyc(6);
    chk("trst_oe", tdo_oe_n, 1'b1);
    tst_u.set_trst(1'b1);
    cyc(6);
    tst_u.step(1'b0, 1'b1, q);
    dr(64'h0, 64);
    chk("trst_id", got, {IDC, IDC});
    $display("test trst done");
  endtask
  task automatic t_off;
    int base;
    sec_reg[SEC_JTAG_OFF] = 1'b1;
    cyc(4);
    chk("off_flag", jtag_off, 1'b1);
    base = oe_cnt;
    tst_u.tlr_rti;
    dr(64'h0, 64);
    chk("off_oe", oe_cnt - base, 64'h0);
    chk("off_tdo", got, 64'h0);
    sec_reg[SEC_JTAG_OFF] = 1'b0;
    cyc(4);
    $display("test off done");
  endtask
  task automatic t_glob;
    sec_reg[SEC_BOOT_OTP] = 1'b1;
    glob_rst_n = 1'b0;
    pll_lock = 1'b0;
    cyc(4);
    chk("glob_boot", boot_go, 1'b0);
    chk("glob_oe", tdo_oe_n, 1'b1);
    glob_rst_n = 1'b1;
    cyc(10);
    chk("relock_wait", boot_go, 1'b0);
    pll_lock = 1'b1;
    cyc(6);
    chk("reboot", boot_go, 1'b1);
    chk("reboot_src", boot_otp, 1'b1);
    $display("test glob done");
  endtask
  initial begin
    rst = 1'b1;
    glob_rst_n = 1'b0;
    pll_lock = 1'b0;
    sec_reg = 32'h0;
    pin_in = 8'h5c;
    acc_rdata = 32'h3c5a_96e1;
    cyc(8);
    rst = 1'b0;
    glob_rst_n = 1'b1;
    tst_u.set_trst(1'b1);
    t_boot;
    t_ident;
    t_ucode(10'h0);
    t_ucode(10'h2a5);
    t_pins;
    t_chip;
    t_trst;
    t_off;
    t_glob;
    close_out;
  end
endmodule // jtid_top_tb

/* rtl/jtid_pkg.sv */
package jtid_pkg;
  localparam int unsigned IR_W = 4;
  localparam int unsigned ID_W = 32;
  localparam int unsigned NPIN = 8;
  localparam int unsigned CDR_W = 34;
  // instruction codes
  localparam logic [3:0] IR_EXTEST  = 4'h0;
  localparam logic [3:0] IR_DEVICE_IDENTIFICATION  = 4'h1;
  localparam logic [3:0] IR_SAMPLE  = 4'h2;
  localparam logic [3:0] IR_CHIPACC = 4'h4;
  localparam logic [3:0] IR_USER    = 4'h8;
  localparam logic [3:0] IR_BYPASS  = 4'hf;
  localparam logic [3:0] IR_CAPT    = 4'h1;
  // identification fields, values arbitrary
  localparam logic [3:0]  IDC_VERSION = 4'h0;
  localparam logic [15:0] IDC_PART    = 16'h0001;
  localparam logic [10:0] IDC_MANUF   = 11'h001;
  localparam logic [15:0] UC_REVISION = 16'h0001;
  localparam logic [5:0]  UC_UNUSED   = 6'h00;
  // security register bit positions
  localparam int unsigned SEC_JTAG_OFF = 0;
  localparam int unsigned SEC_BOOT_OTP = 5;
  localparam int unsigned SEC_OTP_OFF  = 13;
  localparam int unsigned SEC_UID_LO   = 22;
  localparam int unsigned SEC_UID_HI   = 31;
  // chip access targets
  localparam logic [1:0] TGT_TILE   = 2'h0;
  localparam logic [1:0] TGT_SWITCH = 2'h1;
  localparam logic [1:0] TGT_OTP    = 2'h2;
  typedef enum logic [3:0] {
    st_tlr, st_rti, st_seldr, st_capdr, st_shdr, st_ex1dr, st_padr,
    st_ex2dr, st_updr, st_selir, st_capir, st_shir, st_ex1ir, st_pair,
    st_ex2ir, st_upir
  } jtid_tap_e;
endpackage

/* rtl/jtid_tap.sv */
`timescale 1ns/10ps
module jtid_tap (
  input wire logic clk_sys, // system clock
  jtid_tap_if.tap  t        // tap controls and data register hooks
);
  import jtid_pkg::*;

  jtid_tap_e   st_r,   st_nxt;
  logic [3:0]  ir_r,   ir_nxt;
  logic [3:0]  irs_r,  irs_nxt;
  logic [31:0] dr_r,   dr_nxt;
  logic        tdo_r,  tdo_nxt;
  logic        is_id, is_user;

  assign is_id    = (ir_r == IR_DEVICE_IDENTIFICATION);
  assign is_user  = (ir_r == IR_USER);
  assign t.ir     = ir_r;
  assign t.tdo    = tdo_r;
  assign t.cap_dr = t.tck_r && st_r == st_capdr;
  assign t.sh_dr  = t.tck_r && st_r == st_shdr;
  assign t.upd_dr = t.tck_f && st_r == st_updr;
  assign t.shifting = (st_r == st_shdr) || (st_r == st_shir);

  // ****************************************************
  // state, instruction and internal data registers
  // ****************************************************
  always_comb begin
    st_nxt  = st_r;
    ir_nxt  = ir_r;
    irs_nxt = irs_r;
    dr_nxt  = dr_r;
    tdo_nxt = tdo_r;
    if (t.tck_r) begin
      case (st_r)
        st_tlr:   st_nxt = t.tms ? st_tlr   : st_rti;
        st_rti:   st_nxt = t.tms ? st_seldr : st_rti;
        st_seldr: st_nxt = t.tms ? st_selir : st_capdr;
        st_capdr: st_nxt = t.tms ? st_ex1dr : st_shdr;
        st_shdr:  st_nxt = t.tms ? st_ex1dr : st_shdr;
        st_ex1dr: st_nxt = t.tms ? st_updr  : st_padr;
        st_padr:  st_nxt = t.tms ? st_ex2dr : st_padr;
        st_ex2dr: st_nxt = t.tms ? st_updr  : st_shdr;
        st_updr:  st_nxt = t.tms ? st_seldr : st_rti;
        st_selir: st_nxt = t.tms ? st_tlr   : st_capir;
        st_capir: st_nxt = t.tms ? st_ex1ir : st_shir;
        st_shir:  st_nxt = t.tms ? st_ex1ir : st_shir;
        st_ex1ir: st_nxt = t.tms ? st_upir  : st_pair;
        st_pair:  st_nxt = t.tms ? st_ex2ir : st_pair;
        st_ex2ir: st_nxt = t.tms ? st_upir  : st_shir;
        st_upir:  st_nxt = t.tms ? st_seldr : st_rti;
        default:  st_nxt = st_tlr;
      endcase
      case (st_r)
        st_tlr:   ir_nxt = IR_DEVICE_IDENTIFICATION;
        st_capir: irs_nxt = IR_CAPT;
        st_shir:  irs_nxt = {t.tdi, irs_r[3:1]};
        st_capdr: begin
          if (is_id) begin
            dr_nxt = {IDC_VERSION, IDC_PART, IDC_MANUF, 1'b1};
          end else if (is_user) begin
            dr_nxt = t.ucode;
          end else begin
            dr_nxt = 32'h0;
          end
        end
        st_shdr: begin
          if (is_id || is_user) begin
            dr_nxt = {t.tdi, dr_r[31:1]};
          end else begin
            dr_nxt = {31'h0, t.tdi};
          end
        end
        default: ;
      endcase
    end
    if (t.tck_f) begin
      case (st_r)
        st_upir: ir_nxt = irs_r;
        st_shir: tdo_nxt = irs_r[0];
        st_shdr: tdo_nxt = t.cust_sel ? t.cust_tdo : dr_r[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (t.jrst) begin
      st_r  <= st_tlr;
      ir_r  <= IR_DEVICE_IDENTIFICATION;
      irs_r <= IR_CAPT;
      dr_r  <= 32'h0;
      tdo_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      ir_r  <= ir_nxt;
      irs_r <= irs_nxt;
      dr_r  <= dr_nxt;
      tdo_r <= tdo_nxt;
    end
  end
endmodule // jtid_tap

/* rtl/jtid_tap_if.sv */
`timescale 1ns/10ps
interface jtid_tap_if;
  logic        tck_r;
  logic        tck_f;
  logic        tms;
  logic        tdi;
  logic        jrst;
  logic [31:0] ucode;
  logic        cust_sel;
  logic        cust_tdo;
  logic [3:0]  ir;
  logic        cap_dr;
  logic        sh_dr;
  logic        upd_dr;
  logic        shifting;
  logic        tdo;
  modport tap (input tck_r, tck_f, tms, tdi, jrst, ucode, cust_sel,
               cust_tdo, output ir, cap_dr, sh_dr, upd_dr, shifting, tdo);
  modport ctl (output tck_r, tck_f, tms, tdi, jrst, ucode, cust_sel,
               cust_tdo, input ir, cap_dr, sh_dr, upd_dr, shifting, tdo);
endinterface

/* rtl/jtid_top.sv */
`timescale 1ns/10ps
// What this block does
// - two taps per tile in chain after reset
// - boundary scan tap serves the pins
// - chip tap reaches tile, switch, fused memory
// - test reset low keeps all taps reset
// - identification value shifts out, bit zero one
// - user code shifts out ident, unused, revision
// - user ident comes from security bits 31..22
// - blank fuses give all zero user ident
// - global reset active low, asserts asynchronously
// - boot starts only after pll lock returns
// - security bit 0 disables the whole port
// - security bit 13 blocks fused memory access
// - security bits 31..22 extend the user ident
module jtid_top
  import jtid_pkg::*;
(
  input  wire logic                      clk_sys,    // 25 MHz clock
  input  wire logic                      rst,        // sync reset
  input  wire logic                      glob_rst_n, // global reset pin
  input  wire logic                      pll_lock,   // pll locked
  input  wire logic                      tck,        // test clock pin
  input  wire logic                      tms,        // test mode pin
  input  wire logic                      tdi,        // test data in
  input  wire logic                      trst_n,     // test reset pin
  input  wire logic [31:0]               sec_reg,    // tile 0 security
  input  wire logic [jtid_pkg::NPIN-1:0] pin_in,     // pad levels
  input  wire logic [31:0]               acc_rdata,  // access read data
  output logic                           tdo,        // test data out
  output logic                           tdo_oe_n,   // tdo enable, low
  output logic [jtid_pkg::NPIN-1:0]      pin_out,    // scan pad values
  output logic                           pin_ext,    // scan owns pads
  output logic                           acc_req,    // access pulse
  output logic [1:0]                     acc_tgt,    // access target
  output logic [31:0]                    acc_wdata,  // access data
  output logic                           boot_go,    // boot may start
  output logic                           boot_otp,   // boot from fuses
  output logic                           jtag_off    // port disabled
);
  import jtid_pkg::*;

  // ****************************************************
  // reset bridge and pin synchronisers
  // ****************************************************
  logic [1:0]      grst_r;
  logic [12:0]     sy1_r, sy2_r;
  logic            tckd_r;
  logic            dev_rst, jrst, tck_r, tck_f;
  logic            s_tck, s_tms, s_tdi, s_trst_n, s_lock;
  logic [NPIN-1:0] s_pin;

  // assertion lands without a clock; release is clocked
  always_ff @(posedge clk_sys or negedge glob_rst_n) begin
    if (!glob_rst_n) begin
      grst_r <= 2'b00;
    end else begin
      grst_r <= {grst_r[0], 1'b1};
    end
  end
  assign dev_rst = rst || !grst_r[1];

  always_ff @(posedge clk_sys) begin
    sy1_r  <= {pin_in, pll_lock, trst_n, tdi, tms, tck};
    sy2_r  <= sy1_r;
    tckd_r <= sy2_r[0];
  end
  assign s_tck    = sy2_r[0];
  assign s_tms    = sy2_r[1];
  assign s_tdi    = sy2_r[2];
  assign s_trst_n = sy2_r[3];
  assign s_lock   = sy2_r[4];
  assign s_pin    = sy2_r[12:5];
  assign tck_r    = s_tck && !tckd_r;
  assign tck_f    = !s_tck && tckd_r;
  // port held in reset by test reset or security lock
  assign jrst = dev_rst || !s_trst_n || sec_reg[SEC_JTAG_OFF];

  // ****************************************************
  // boot sequencing
  // ****************************************************
  logic boot_go_r, boot_go_nxt, boot_otp_r, boot_otp_nxt;
  always_comb begin
    boot_go_nxt  = boot_go_r;
    boot_otp_nxt = boot_otp_r;
    if (!boot_go_r && s_lock) begin
      boot_go_nxt  = 1'b1;
      boot_otp_nxt = sec_reg[SEC_BOOT_OTP];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (dev_rst) begin
      boot_go_r  <= 1'b0;
      boot_otp_r <= 1'b0;
    end else begin
      boot_go_r  <= boot_go_nxt;
      boot_otp_r <= boot_otp_nxt;
    end
  end

  // ****************************************************
  // the two taps, boundary first then chip
  // ****************************************************
  jtid_tap_if bs_if ();
  jtid_tap_if cp_if ();
  logic [31:0]      ucode;
  logic [NPIN-1:0]  bsr_r, bsr_nxt, bsu_r, bsu_nxt;
  logic [CDR_W-1:0] cdr_r, cdr_nxt;
  logic             bs_scan, cp_acc, otp_blk;

  // blank fuses read as zero, so nothing substitutes here
  assign ucode = {sec_reg[SEC_UID_HI:SEC_UID_LO], UC_UNUSED,
                  UC_REVISION};
  assign bs_scan = bs_if.ir == IR_EXTEST || bs_if.ir == IR_SAMPLE;
  assign cp_acc  = cp_if.ir == IR_CHIPACC;
  assign otp_blk = sec_reg[SEC_OTP_OFF] && cdr_r[33:32] == TGT_OTP;

  assign bs_if.tck_r    = tck_r;
  assign bs_if.tck_f    = tck_f;
  assign bs_if.tms      = s_tms;
  assign bs_if.tdi      = s_tdi;
  assign bs_if.jrst     = jrst;
  assign bs_if.ucode    = ucode;
  assign bs_if.cust_sel = bs_scan;
  assign bs_if.cust_tdo = bsr_r[0];
  // chip tap follows in the chain, fed by the first tap's output
  assign cp_if.tck_r    = tck_r;
  assign cp_if.tck_f    = tck_f;
  assign cp_if.tms      = s_tms;
  assign cp_if.tdi      = bs_if.tdo;
  assign cp_if.jrst     = jrst;
  assign cp_if.ucode    = ucode;
  assign cp_if.cust_sel = cp_acc;
  assign cp_if.cust_tdo = cdr_r[0];

  jtid_tap u_bs_tap (
    .clk_sys (clk_sys),
    .t       (bs_if)
  );
  jtid_tap u_cp_tap (
    .clk_sys (clk_sys),
    .t       (cp_if)
  );

  // ****************************************************
  // boundary scan and chip access data registers
  // ****************************************************
  logic       req_nxt, req_r, ext_nxt, ext_r;
  logic [1:0] tgt_nxt, tgt_r;
  logic [31:0] wd_nxt, wd_r;

  always_comb begin
    bsr_nxt = bsr_r;
    bsu_nxt = bsu_r;
    cdr_nxt = cdr_r;
    req_nxt = 1'b0;
    tgt_nxt = tgt_r;
    wd_nxt  = wd_r;
    ext_nxt = bs_if.ir == IR_EXTEST;
    if (bs_scan) begin
      if (bs_if.cap_dr) begin
        bsr_nxt = s_pin;
      end else if (bs_if.sh_dr) begin
        bsr_nxt = {bs_if.tdi, bsr_r[NPIN-1:1]};
      end else if (bs_if.upd_dr) begin
        bsu_nxt = bsr_r;
      end
    end
    if (cp_acc) begin
      if (cp_if.cap_dr) begin
        // blocked fused reads return zero, target kept
        cdr_nxt = {cdr_r[33:32], otp_blk ? 32'h0 : acc_rdata};
      end else if (cp_if.sh_dr) begin
        cdr_nxt = {cp_if.tdi, cdr_r[CDR_W-1:1]};
      end else if (cp_if.upd_dr && !otp_blk) begin
        req_nxt = 1'b1;
        tgt_nxt = cdr_r[33:32];
        wd_nxt  = cdr_r[31:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (jrst) begin
      bsr_r <= '0;
      bsu_r <= '0;
      cdr_r <= '0;
      req_r <= 1'b0;
      tgt_r <= TGT_TILE;
      wd_r  <= 32'h0;
      ext_r <= 1'b0;
    end else begin
      bsr_r <= bsr_nxt;
      bsu_r <= bsu_nxt;
      cdr_r <= cdr_nxt;
      req_r <= req_nxt;
      tgt_r <= tgt_nxt;
      wd_r  <= wd_nxt;
      ext_r <= ext_nxt;
    end
  end

  // ****************************************************
  // test data out
  // ****************************************************
  logic tdo_r, tdo_nxt, oen_r, oen_nxt;
  always_comb begin
    tdo_nxt = cp_if.tdo;
    // floats unless one of the taps is shifting
    oen_nxt = !(bs_if.shifting || cp_if.shifting);
  end
  always_ff @(posedge clk_sys) begin
    if (jrst) begin
      tdo_r <= 1'b0;
      oen_r <= 1'b1;
    end else begin
      tdo_r <= tdo_nxt;
      oen_r <= oen_nxt;
    end
  end

  logic off_r;
  always_ff @(posedge clk_sys) begin
    if (dev_rst) begin
      off_r <= 1'b0;
    end else begin
      off_r <= sec_reg[SEC_JTAG_OFF];
    end
  end

  assign tdo       = tdo_r;
  assign tdo_oe_n  = oen_r;
  assign pin_out   = bsu_r;
  assign pin_ext   = ext_r;
  assign acc_req   = req_r;
  assign acc_tgt   = tgt_r;
  assign acc_wdata = wd_r;
  assign boot_go   = boot_go_r;
  assign boot_otp  = boot_otp_r;
  assign jtag_off  = off_r;
endmodule // jtid_top
